// ==== rtl/mdu_pkg.sv ====
// constants and carriers for the multiply/divide unit of the core
// assumes one pipeline clock and a synchronous active-high core reset
// Summary of operation
// - every multiply or divide result except the direct multiply lands in one selected pair out of four high/low accumulator pairs.
// - move-from-high and move-from-low copy the selected pair's high or low word to a general register.
// - the direct multiply writes its low result word to a general register and leaves the pairs untouched.
// - multiply-add adds the product to the selected pair and stores the sum back there.
// - multiply-subtract takes the product from the selected pair and stores the difference back there.
// - shift operations read and write a pair, alongside the extra signal-processing multiply forms.
// - three extra pairs beyond the base pair give four selectable pairs.
// - multiplies and dot products without saturation finish in 5 clocks and may issue every clock.
// - multiplies and dot products with saturation also finish in 5 clocks at one per clock.
// - signal-processing multiplies without accumulation finish in 5 clocks at one per clock.
package mdu_pkg;
    localparam int unsigned data_width = 32;
    localparam int unsigned acc_pairs = 4;
    localparam int unsigned acc_sel_width = 2;
    localparam int unsigned gpr_addr_width = 5;
    localparam int unsigned mult_latency = 5;
    localparam int unsigned div_steps = 32;
    localparam int unsigned div_count_width = 6;
    localparam logic [63:0] sat_max = 64'h7fffffffffffffff;
    localparam logic [63:0] sat_min = 64'h8000000000000000;

    typedef enum logic [3:0] {
        op_mult, op_multu, op_multiply_add, op_maddu, op_multiply_subtract, op_msubu, op_direct_mul,
        op_multiply_add_sat, op_multiply_subtract_sat, op_dot_add, op_shift_right, op_shift_left,
        op_mthi, op_mtlo, op_div, op_divu
    } op_type;

    typedef struct packed {
        logic valid;
        op_type op;
        logic [acc_sel_width-1:0] acc;
        logic [gpr_addr_width-1:0] dest;
        logic [data_width-1:0] a;
        logic [data_width-1:0] b;
    } issue_type;

    typedef struct packed {
        logic valid;
        logic high;
        logic [acc_sel_width-1:0] acc;
        logic [gpr_addr_width-1:0] dest;
    } move_type;

    typedef struct packed {
        logic valid;
        logic [gpr_addr_width-1:0] dest;
        logic [data_width-1:0] data;
    } gpr_write_type;

    typedef struct packed {
        logic valid;
        op_type op;
        logic [acc_sel_width-1:0] acc;
        logic [gpr_addr_width-1:0] dest;
        logic [63:0] product;
    } stage_type;
endpackage

// ==== rtl/mult_pipe.sv ====
// five-stage pipelined 32x32 multiplier, one product per clock
// assumes operands held stable only in the issue cycle
`timescale 1ns/1ps
`default_nettype none
module mult_pipe
    import mdu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire issue_type issue,
    output stage_type result
);
    stage_type stage_reg [mult_latency];
    stage_type stage_next [mult_latency];
    logic sign_op;
    logic [63:0] prod;

    // first stage forms the product, later stages only delay it
    always_comb begin
        sign_op = !(issue.op inside {op_multu, op_maddu, op_msubu});
        if (sign_op) begin
            prod = 64'($signed(issue.a) * $signed(issue.b));
        end else begin
            prod = 64'(issue.a * issue.b);
        end
        stage_next[0].valid = issue.valid;
        stage_next[0].op = issue.op;
        stage_next[0].acc = issue.acc;
        stage_next[0].dest = issue.dest;
        stage_next[0].product = prod;
    end

    // pipeline shift, one stage per clock
    generate
        for (genvar s = 1; s < mult_latency; s++) begin : g_stage
            always_comb begin
                stage_next[s] = stage_reg[s-1];
            end
        end
    endgenerate

    always_ff @(posedge clk) begin
        for (int s = 0; s < mult_latency; s++) begin
            if (rst) begin
                stage_reg[s] <= '0;
            end else begin
                stage_reg[s] <= stage_next[s];
            end
        end
    end

    assign result = stage_reg[mult_latency-1];
endmodule
`default_nettype wire

// ==== rtl/acc_file.sv ====
// four high/low accumulator pairs, registered read port
// assumes a single write per clock from the owning unit
`timescale 1ns/1ps
`default_nettype none
module acc_file
    import mdu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [acc_sel_width-1:0] wr_sel,
    input wire logic [63:0] wr_data,
    input wire logic [acc_sel_width-1:0] rd_sel,
    output logic [63:0] rd_data,
    output logic [63:0] peek [acc_pairs]
);
    logic [63:0] pair_reg [acc_pairs];
    logic [63:0] pair_next [acc_pairs];
    logic [63:0] rd_reg;
    logic [63:0] rd_next;

    // base pair plus three extra pairs
    generate
        for (genvar p = 0; p < acc_pairs; p++) begin : g_pair
            always_comb begin
                pair_next[p] = pair_reg[p];
                if (wr_en && wr_sel == acc_sel_width'(p)) begin
                    pair_next[p] = wr_data;
                end
            end
            always_ff @(posedge clk) begin
                if (rst) begin
                    pair_reg[p] <= '0;
                end else begin
                    pair_reg[p] <= pair_next[p];
                end
            end
            assign peek[p] = pair_reg[p];
        end
    endgenerate

    // registered read of the selected pair
    always_comb begin
        rd_next = pair_reg[rd_sel];
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rd_reg <= '0;
        end else begin
            rd_reg <= rd_next;
        end
    end

    assign rd_data = rd_reg;
endmodule
`default_nettype wire

// ==== rtl/multiply_divide_unit.sv ====
// multiply/divide unit: accumulator pairs, multiplier pipe, divider, moves
// assumes the pipeline holds a request while busy is high
`timescale 1ns/1ps
`default_nettype none
module multiply_divide_unit
    import mdu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire issue_type issue,
    input wire move_type move,
    input wire logic [gpr_addr_width-1:0] read_reg_a,
    input wire logic [gpr_addr_width-1:0] read_reg_b,
    output logic busy,
    output gpr_write_type gpr_write
);
    typedef enum {st_idle, st_div, st_move} state_type;

    state_type state_reg, state_next;
    stage_type tail;
    issue_type pipe_in;
    logic [63:0] acc_now [acc_pairs];
    logic [63:0] acc_rd;
    logic acc_wr_en;
    logic [acc_sel_width-1:0] acc_wr_sel;
    logic [63:0] acc_wr_data;
    logic [acc_pairs-1:0] acc_pend_reg, acc_pend_next;
    logic [31:0] gpr_pend_reg, gpr_pend_next;
    logic [mult_latency-1:0] pend_age_acc [acc_pairs];
    logic busy_reg, busy_next;
    gpr_write_type gw_reg, gw_next;
    move_type mv_reg, mv_next;
    logic [div_count_width-1:0] div_cnt_reg, div_cnt_next;
    logic [63:0] div_rem_reg, div_rem_next;
    logic [31:0] div_quo_reg, div_quo_next;
    logic [31:0] div_den_reg, div_den_next;
    logic div_neg_q_reg, div_neg_q_next;
    logic div_neg_r_reg, div_neg_r_next;
    logic [acc_sel_width-1:0] div_acc_reg, div_acc_next;
    logic [64:0] sum_ext;
    logic [64:0] diff_ext;
    logic accept;
    logic hazard;
    logic [31:0] a_abs, b_abs;

    mult_pipe u_mult (
        .clk(clk),
        .rst(rst),
        .issue(pipe_in),
        .result(tail)
    );

    acc_file u_acc (
        .clk(clk),
        .rst(rst),
        .wr_en(acc_wr_en),
        .wr_sel(acc_wr_sel),
        .wr_data(acc_wr_data),
        .rd_sel(move.acc), // data stands in the move state cycle
        .rd_data(acc_rd),
        .peek(acc_now)
    );

    // hazard check on pending pair or multiply destination
    always_comb begin
        hazard = 1'b0;
        if (move.valid && acc_pend_reg[move.acc]) begin
            hazard = 1'b1;
        end
        if (issue.valid && acc_pend_reg[issue.acc] &&
            issue.op inside {op_shift_right, op_shift_left, op_mthi, op_mtlo}) begin
            hazard = 1'b1;
        end
        if (gpr_pend_reg[read_reg_a] || gpr_pend_reg[read_reg_b]) begin
            hazard = 1'b1;
        end
        accept = (state_reg == st_idle) && !hazard;
        pipe_in = issue;
        pipe_in.valid = issue.valid && accept &&
            !(issue.op inside {op_shift_right, op_shift_left, op_mthi, op_mtlo, op_div, op_divu});
    end

    // pending scoreboard follows the pipe tail
    always_comb begin
        acc_pend_next = acc_pend_reg;
        gpr_pend_next = gpr_pend_reg;
        if (tail.valid) begin
            if (tail.op == op_direct_mul) begin
                gpr_pend_next[tail.dest] = 1'b0;
            end else begin
                acc_pend_next[tail.acc] = |pend_age_acc[tail.acc][mult_latency-2:0];
            end
        end
        if (pipe_in.valid) begin
            if (issue.op == op_direct_mul) begin
                gpr_pend_next[issue.dest] = 1'b1;
            end else begin
                acc_pend_next[issue.acc] = 1'b1;
            end
        end
        if (state_reg == st_div) begin
            acc_pend_next[div_acc_reg] = (div_cnt_reg != '0); // clear on the final write
        end
    end

    // per-pair age masks tell when the last pending product drains
    generate
        for (genvar p = 0; p < acc_pairs; p++) begin : g_age
            logic [mult_latency-1:0] age_reg;
            always_ff @(posedge clk) begin
                if (rst) begin
                    age_reg <= '0;
                end else begin
                    age_reg <= {age_reg[mult_latency-2:0], pipe_in.valid && issue.op != op_direct_mul &&
                        issue.acc == acc_sel_width'(p)};
                end
            end
            assign pend_age_acc[p] = age_reg;
        end
    endgenerate

    // accumulator write: product tail, shift, move-to, or divider
    always_comb begin
        acc_wr_en = 1'b0;
        acc_wr_sel = tail.acc;
        acc_wr_data = tail.product;
        sum_ext = {acc_now[tail.acc][63], acc_now[tail.acc]} + {tail.product[63], tail.product};
        diff_ext = {acc_now[tail.acc][63], acc_now[tail.acc]} - {tail.product[63], tail.product};
        if (tail.valid && tail.op != op_direct_mul) begin
            acc_wr_en = 1'b1;
            unique case (tail.op)
                op_multiply_add, op_maddu, op_dot_add: acc_wr_data = sum_ext[63:0];
                op_multiply_subtract, op_msubu: acc_wr_data = diff_ext[63:0];
                op_multiply_add_sat: begin
                    acc_wr_data = sum_ext[63:0];
                    if (sum_ext[64] != sum_ext[63]) begin
                        acc_wr_data = sum_ext[64] ? sat_min : sat_max;
                    end
                end
                op_multiply_subtract_sat: begin
                    acc_wr_data = diff_ext[63:0];
                    if (diff_ext[64] != diff_ext[63]) begin
                        acc_wr_data = diff_ext[64] ? sat_min : sat_max;
                    end
                end
                default: acc_wr_data = tail.product;
            endcase
        end else if (issue.valid && accept && issue.op inside {op_shift_right, op_shift_left}) begin
            acc_wr_en = 1'b1;
            acc_wr_sel = issue.acc;
            if (issue.op == op_shift_right) begin
                acc_wr_data = 64'($signed(acc_now[issue.acc]) >>> issue.b[5:0]);
            end else begin
                acc_wr_data = acc_now[issue.acc] << issue.b[5:0];
            end
        end else if (issue.valid && accept && issue.op inside {op_mthi, op_mtlo}) begin
            acc_wr_en = 1'b1;
            acc_wr_sel = issue.acc;
            acc_wr_data = (issue.op == op_mthi) ? {issue.a, acc_now[issue.acc][31:0]}
                                                : {acc_now[issue.acc][63:32], issue.a};
        end else if (state_reg == st_div && div_cnt_reg == '0) begin
            acc_wr_en = 1'b1;
            acc_wr_sel = div_acc_reg;
            acc_wr_data = {div_neg_r_reg ? -div_rem_reg[63:32] : div_rem_reg[63:32],
                           div_neg_q_reg ? -div_quo_reg : div_quo_reg};
        end
    end

    // divider and move sequencing
    always_comb begin
        state_next = state_reg;
        mv_next = mv_reg;
        div_cnt_next = div_cnt_reg;
        div_rem_next = div_rem_reg;
        div_quo_next = div_quo_reg;
        div_den_next = div_den_reg;
        div_neg_q_next = div_neg_q_reg;
        div_neg_r_next = div_neg_r_reg;
        div_acc_next = div_acc_reg;
        gw_next = '0;
        a_abs = (issue.op == op_div && issue.a[31]) ? -issue.a : issue.a;
        b_abs = (issue.op == op_div && issue.b[31]) ? -issue.b : issue.b;
        if (tail.valid && tail.op == op_direct_mul) begin
            gw_next.valid = 1'b1;
            gw_next.dest = tail.dest;
            gw_next.data = tail.product[31:0];
        end
        unique case (state_reg)
            st_idle: begin
                if (move.valid && accept && !(tail.valid && tail.op == op_direct_mul)) begin
                    mv_next = move;
                    state_next = st_move;
                end else if (issue.valid && accept && issue.op inside {op_div, op_divu}) begin
                    div_rem_next = {32'h0, a_abs};
                    div_den_next = b_abs;
                    div_quo_next = '0;
                    div_cnt_next = div_count_width'(div_steps);
                    div_neg_q_next = (issue.op == op_div) && (issue.a[31] ^ issue.b[31]);
                    div_neg_r_next = (issue.op == op_div) && issue.a[31];
                    div_acc_next = issue.acc;
                    state_next = st_div;
                end
            end
            st_move: begin
                gw_next.valid = 1'b1;
                gw_next.dest = mv_reg.dest;
                gw_next.data = mv_reg.high ? acc_rd[63:32] : acc_rd[31:0];
                state_next = st_idle;
            end
            st_div: begin
                if (div_cnt_reg == '0) begin
                    state_next = st_idle;
                end else begin
                    div_cnt_next = div_cnt_reg - 1'b1;
                    div_rem_next = {div_rem_reg[62:0], 1'b0};
                    div_quo_next = {div_quo_reg[30:0], 1'b0};
                    if ({div_rem_reg[62:0], 1'b0} >= {div_den_reg, 32'h0}) begin
                        div_rem_next = {div_rem_reg[62:0], 1'b0} - {div_den_reg, 32'h0};
                        div_quo_next = {div_quo_reg[30:0], 1'b1};
                    end
                end
            end
        endcase
        busy_next = (state_next != st_idle) || (|acc_pend_next) || (|gpr_pend_next);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= st_idle;
            mv_reg <= '0;
            div_cnt_reg <= '0;
            div_rem_reg <= '0;
            div_quo_reg <= '0;
            div_den_reg <= '0;
            div_neg_q_reg <= 1'b0;
            div_neg_r_reg <= 1'b0;
            div_acc_reg <= '0;
            acc_pend_reg <= '0;
            gpr_pend_reg <= '0;
            busy_reg <= 1'b0;
            gw_reg <= '0;
        end else begin
            state_reg <= state_next;
            mv_reg <= mv_next;
            div_cnt_reg <= div_cnt_next;
            div_rem_reg <= div_rem_next;
            div_quo_reg <= div_quo_next;
            div_den_reg <= div_den_next;
            div_neg_q_reg <= div_neg_q_next;
            div_neg_r_reg <= div_neg_r_next;
            div_acc_reg <= div_acc_next;
            acc_pend_reg <= acc_pend_next;
            gpr_pend_reg <= gpr_pend_next;
            busy_reg <= busy_next;
            gw_reg <= gw_next;
        end
    end

    // outputs straight from flip-flops
    assign busy = busy_reg;
    assign gpr_write = gw_reg;
endmodule
`default_nettype wire

// ==== sim/mdu_assertions.sv ====
// port checks for the multiply/divide unit
// assumes one pipeline clock and the synchronous reset of the core
`timescale 1ns/1ps
`default_nettype none
module mdu_checker
    import mdu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire issue_type issue,
    input wire move_type move,
    input wire logic [gpr_addr_width-1:0] read_reg_a,
    input wire logic [gpr_addr_width-1:0] read_reg_b,
    input wire logic busy,
    input wire gpr_write_type gpr_write
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic dm_start;
    logic mul_start;
    logic acc_mul;
    logic [data_width-1:0] dm_low;
    // request decode
    assign dm_start = issue.valid && issue.op == op_direct_mul;
    assign mul_start = issue.valid && issue.op inside {op_mult, op_multu, op_multiply_add, op_maddu, op_multiply_subtract,
        op_msubu, op_direct_mul, op_multiply_add_sat, op_multiply_subtract_sat, op_dot_add};
    assign acc_mul = mul_start && !dm_start;
    assign dm_low = issue.a * issue.b;

    AST_BUSY_HOLD: assert property ((mul_start && !busy && !move.valid) |=> busy [*5])
        else $error("busy dropped while a multiply was pending");
    AST_BUSY_RELEASE: assert property ((acc_mul && !busy && !move.valid) ##1
        (!issue.valid && !move.valid) [*6] |-> !busy)
        else $error("busy still high after multiply latency");
    AST_DM_LATENCY: assert property ((dm_start && !busy && !move.valid) |->
        ##6 (gpr_write.valid && gpr_write.dest == $past(issue.dest, 6)))
        else $error("direct multiply write late or to wrong register");
    AST_DM_DATA: assert property ((dm_start && !busy && !move.valid) |->
        ##6 (gpr_write.data == $past(dm_low, 6)))
        else $error("direct multiply low word wrong");
    AST_DM_REPEAT: assert property ((dm_start && !busy && !move.valid) ##1 dm_start |->
        ##5 gpr_write.valid ##1 gpr_write.valid)
        else $error("back to back direct multiplies not one per clock");
    AST_MOVE_LATENCY: assert property ((move.valid && !issue.valid && !busy && !gpr_write.valid) |->
        ##2 (gpr_write.valid && gpr_write.dest == $past(move.dest, 2)))
        else $error("move result late or to wrong register");
    AST_ACC_NO_GPR: assert property ((acc_mul && !busy && !move.valid) |=> !gpr_write.valid [*6])
        else $error("accumulator multiply wrote a general register");
    AST_GPR_CAUSE: assert property (gpr_write.valid |-> ($past(dm_start, 6) || $past(move.valid, 2)))
        else $error("general register write without a cause");
endmodule
bind multiply_divide_unit mdu_checker i_chk (.clk(clk), .rst(rst), .issue(issue), .move(move),
    .read_reg_a(read_reg_a), .read_reg_b(read_reg_b), .busy(busy), .gpr_write(gpr_write));
`default_nettype wire

// ==== sim/gpr_file_model.sv ====
// general register file model of the pipeline side
// assumes writes arrive as one-cycle pulses from the unit
`timescale 1ns/1ps
`default_nettype none
module gpr_file_model
    import mdu_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire gpr_write_type gpr_write,
    output logic [data_width-1:0] regs [32]
);
    // capture each write pulse into the register array
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 32; i++) regs[i] <= '0;
        end else if (gpr_write.valid) begin
            regs[gpr_write.dest] <= gpr_write.data;
        end
    end
endmodule
`default_nettype wire

// ==== sim/test_multiply_accumulate_unit.sv ====
// self-checking bench for the multiply/divide unit
// assumes the unit takes requests at the edge after they are driven
`timescale 1ns/1ps
`default_nettype none
module test_multiply_accumulate_unit;
    import mdu_pkg::*;
    logic clk;
    logic rst;
    issue_type issue;
    move_type move;
    logic [gpr_addr_width-1:0] read_reg_a;
    logic [gpr_addr_width-1:0] read_reg_b;
    logic busy;
    gpr_write_type gpr_write;
    logic [data_width-1:0] regs [32];
    int mismatches;
    int check_count;
    int cycles;
    logic [63:0] p [4];

    multiply_divide_unit i_dut (.clk(clk), .rst(rst), .issue(issue), .move(move), .read_reg_a(read_reg_a),
        .read_reg_b(read_reg_b), .busy(busy), .gpr_write(gpr_write));
    gpr_file_model i_regs (.clk(clk), .rst(rst), .gpr_write(gpr_write), .regs(regs));

    // pipeline clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            mismatches = mismatches + 1;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [63:0] smul(input logic [31:0] a, input logic [31:0] b);
        return $signed({{32{a[31]}}, a}) * $signed({{32{b[31]}}, b});
    endfunction

    // drive one request, held over one taking edge
    task automatic put(input op_type o, input logic [1:0] c, input logic [4:0] d, input logic [31:0] a,
        input logic [31:0] b);
        issue <= '{1'b1, o, c, d, a, b};
        @(posedge clk);
    endtask

    // release the request and wait for idle
    task automatic settle();
        int n;
        issue.valid <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (busy !== 1'b0 && n < 60);
        if (n >= 60) check(64'h1, 64'h0);
    endtask

    // read a pair through move-from-high then move-from-low
    task automatic rd(input logic [1:0] c, output logic [63:0] v);
        logic got;
        v = '0;
        for (int h = 1; h >= 0; h--) begin
            move <= '{1'b1, h[0], c, 5'd1};
            @(posedge clk);
            move.valid <= 1'b0;
            got = 1'b0;
            for (int k = 0; k < 8 && !(got && busy === 1'b0); k++) begin
                @(posedge clk);
                if (gpr_write.valid === 1'b1) begin
                    v[h*32 +: 32] = gpr_write.data;
                    got = 1'b1;
                end
            end
            check(got, 64'h1);
        end
    endtask

    task automatic t_reset_pairs();
        logic [63:0] v;
        for (int c = 0; c < acc_pairs; c++) begin
            rd(c[1:0], v);
            check(v, 64'h0);
        end
        check(busy, 64'h0);
    endtask

    task automatic t_pairs();
        logic [63:0] v;
        for (int c = 0; c < acc_pairs; c++) begin
            put(op_mult, c[1:0], 5'd0, 32'h0000_1000 + c, 32'hffff_fffd);
            p[c] = smul(32'h0000_1000 + c, 32'hffff_fffd);
        end
        settle();
        for (int c = 0; c < acc_pairs; c++) begin
            rd(c[1:0], v);
            check(v, p[c]);
        end
    endtask

    task automatic t_accumulate();
        logic [63:0] v;
        put(op_multiply_add, 2'd1, 5'd0, 32'h0000_0007, 32'h0000_0009);
        settle();
        put(op_multiply_subtract, 2'd1, 5'd0, 32'hffff_fffe, 32'h0000_0064);
        settle();
        p[1] = p[1] + 64'h107;
        rd(2'd1, v);
        check(v, p[1]);
    endtask

    task automatic t_direct();
        logic [63:0] v;
        put(op_direct_mul, 2'd0, 5'd5, 32'h0001_0003, 32'h0000_0100);
        put(op_direct_mul, 2'd0, 5'd6, 32'hffff_ffff, 32'h0000_0002);
        settle();
        @(posedge clk);
        check(regs[5], 64'h0100_0300);
        check(regs[6], 64'hffff_fffe);
        rd(2'd0, v);
        check(v, p[0]);
    endtask

    task automatic t_shift();
        logic [63:0] v;
        put(op_shift_right, 2'd3, 5'd0, 32'h0000_0004, 32'h0000_0004);
        settle();
        put(op_shift_left, 2'd0, 5'd0, 32'h0000_0004, 32'h0000_0004);
        settle();
        rd(2'd3, v);
        check(v, {{4{p[3][63]}}, p[3][63:4]});
        rd(2'd0, v);
        check(v, p[0] << 4);
    endtask

    task automatic t_saturate();
        logic [63:0] v;
        put(op_mthi, 2'd2, 5'd0, 32'h7fff_ffff, 32'h7fff_ffff);
        settle();
        put(op_mtlo, 2'd2, 5'd0, 32'hffff_ffff, 32'hffff_ffff);
        settle();
        put(op_multiply_add_sat, 2'd2, 5'd0, 32'h0000_0005, 32'h0000_0005);
        settle();
        rd(2'd2, v);
        check(v, sat_max);
    endtask

    task automatic t_hazard();
        logic seen;
        read_reg_a <= 5'd9;
        put(op_direct_mul, 2'd0, 5'd9, 32'h0000_0011, 32'h0000_0011);
        issue.valid <= 1'b0;
        seen = 1'b0;
        for (int k = 0; k < 12 && !seen; k++) begin
            @(posedge clk);
            if (gpr_write.valid === 1'b1) seen = 1'b1;
            else check(busy, 64'h1);
        end
        check(seen, 64'h1);
        check(gpr_write.data, 64'h121);
        read_reg_a <= 5'd0;
        settle();
    endtask

    task automatic t_divide();
        logic [63:0] v;
        put(op_divu, 2'd1, 5'd0, 32'h0000_0064, 32'h0000_0007);
        settle();
        rd(2'd1, v);
        check(v, 64'h0000_0002_0000_000e);
    endtask

    // main sequence
    initial begin
        rst = 1'b1;
        issue = '0;
        move = '0;
        read_reg_a = '0;
        read_reg_b = '0;
        mismatches = 0;
        check_count = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_pairs();
        t_pairs();
        t_accumulate();
        t_direct();
        t_shift();
        t_saturate();
        t_hazard();
        t_divide();
        end_of_test();
    end
endmodule
`default_nettype wire
